// [swu_pkg.sv]
package swu_pkg;
   localparam int          CLK_HZ       = 125_000_000;
   localparam int          MIN_BAUD     = 9000;
   // Bit time assumed until the first good datagram sets a measured one.
   localparam int          BIT_INIT     = CLK_HZ / MIN_BAUD;
   localparam int          CNT_W        = 20;
   localparam int          GAP_W        = CNT_W + 6;
   localparam int          GLITCH_CYC   = 16;
   localparam int          MIN_BIT_CYC  = 16;
   localparam int          TIMEOUT_BITS = 63;
   localparam int          RECOV_BITS   = 12;
   localparam int          HOLD_BITS    = 4;
   localparam int          DELAY_UNIT   = 8;
   localparam logic [7:0]  SYNC_BYTE    = 8'h05;
   localparam logic [7:0]  SYNC_PRELOAD = 8'ha0;
   localparam logic [6:0]  SYNC_IDX     = 7'h04;
   localparam logic [7:0]  CRC_POLY     = 8'h07;
   localparam logic [2:0]  WR_LAST      = 3'h6;
   localparam logic [2:0]  RD_LAST      = 3'h2;
   localparam int          TX_BYTES     = 7;
   localparam int          TX_BITS      = TX_BYTES * 10;
   localparam int          WR_W         = 39;

   typedef enum logic [3:0] {
      S_IDLE   = 4'h0,
      S_MEAS   = 4'h1,
      S_BYTE   = 4'h3,
      S_WAITB  = 4'h2,
      S_COMMIT = 4'h6,
      S_DELAY  = 4'h7,
      S_SEND   = 4'h5,
      S_HOLD   = 4'h4,
      S_RECOV  = 4'hc
   } swu_state_e;

   // Check byte update, one byte taken least significant bit first.
   function automatic logic [7:0] swu_crc(input logic [7:0] c,
                                          input logic [7:0] b);
      logic [7:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         r = {r[6:0], 1'b0} ^ (((r[7] ^ b[i]) == 1'b1) ? CRC_POLY : 8'h00);
      end
      return r;
   endfunction
endpackage

// [swu_stream_if.sv]
`timescale 1ns/1ps
interface swu_stream_if #(parameter int W = 39);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [swu_buf.sv]
`timescale 1ns/1ps
// Two-entry skid buffer: the second entry catches a word offered in the
// cycle the receiver stalls, so ready may be a flop without losing data.
module swu_buf
   import swu_pkg::*;
#(
   parameter int W = 39
)
(
   input  wire logic         core_clk,
   input  wire logic         rst,
   swu_stream_if.snk         in_s,
   output wire logic         out_valid,
   input  wire logic         out_ready,
   output wire logic [W-1:0] out_data
);
   logic         val_ff;
   logic         nxt_val;
   logic [W-1:0] dat_ff;
   logic [W-1:0] nxt_dat;
   logic         skv_ff;
   logic         nxt_skv;
   logic [W-1:0] skd_ff;
   logic [W-1:0] nxt_skd;

   always_comb
   begin
      nxt_val = val_ff;
      nxt_dat = dat_ff;
      nxt_skv = skv_ff;
      nxt_skd = skd_ff;
      if (out_ready || !val_ff)
      begin
         if (skv_ff)
         begin
            nxt_val = 1'b1;
            nxt_dat = skd_ff;
            nxt_skv = 1'b0;
         end
         else
         begin
            nxt_val = in_s.valid;
            nxt_dat = in_s.data;
         end
      end
      else if (in_s.valid && !skv_ff)
      begin
         nxt_skv = 1'b1;
         nxt_skd = in_s.data;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         val_ff <= 1'b0;
         dat_ff <= '0;
         skv_ff <= 1'b0;
         skd_ff <= '0;
      end
      else
      begin
         val_ff <= nxt_val;
         dat_ff <= nxt_dat;
         skv_ff <= nxt_skv;
         skd_ff <= nxt_skd;
      end
   end

   assign in_s.ready = !skv_ff;
   assign out_valid  = val_ff;
   assign out_data   = dat_ff;

   skid_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      val_ff && !out_ready |=> val_ff && $stable(dat_ff))
      else $error("buffered word changed while stalled");
endmodule

// [swu_slave.sv]
`timescale 1ns/1ps
// Overview of operation
// - Every frame starts with sync byte whose upper nibble is zero.
// - Write: sync, access/address byte, four data bytes, check byte.
// - Bits least significant first; data word highest byte first.
// - Bit time is re-measured from the sync of every datagram.
// - Each byte has a low start bit and a high stop bit.
// - Bit time is a quarter of start-bit fall to fall between bits 2 and 3.
// - Gap over 63 bit times between start bits resets reception.
// - Idle pulse under 16 clocks is a glitch; needs 12 idle bits.
// - Check byte or framing errors recover like a glitch.
// - Each accepted write increments an 8-bit wrapping counter.
// - Read requests leave the datagram counter unchanged.
// - One shared line; device drives only while replying and during the hold after it.
// - Check byte is CRC x8+x2+x+1, zero start, LSB first.
// - Reply starts after delay of eight-bit-time multiples.
// - Line drivers released four bit times after last reply bit.
// - Top address bit: zero read, one write.
module swu_slave
   import swu_pkg::*;
#(
   parameter int BIT_RESET = BIT_INIT
)
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        wire_data_true_in,
   output wire logic        wire_data_true_out,
   output wire logic        wire_data_true_oe,
   input  wire logic [3:0]  reply_delay_setting,
   output wire logic        wr_valid,
   input  wire logic        wr_ready,
   output wire logic [6:0]  wr_addr,
   output wire logic [31:0] wr_data,
   output wire logic        rd_req,
   output wire logic [6:0]  rd_addr,
   input  wire logic [31:0] rd_data,
   output wire logic [7:0]  dgram_count
);
   logic              rx_s1_ff;
   logic              rx_s2_ff;
   logic              rx_prv_ff;
   logic              fall;
   logic              rise;
   swu_state_e        state_ff;
   swu_state_e        nxt_state;
   logic [CNT_W-1:0]  cnt_ff;
   logic [CNT_W-1:0]  nxt_cnt;
   logic [GAP_W-1:0]  gap_ff;
   logic [GAP_W-1:0]  nxt_gap;
   logic [CNT_W-1:0]  bit_ff;
   logic [CNT_W-1:0]  nxt_bit;
   logic [CNT_W-1:0]  good_ff;
   logic [CNT_W-1:0]  nxt_good;
   logic [6:0]        idx_ff;
   logic [6:0]        nxt_idx;
   logic [2:0]        byte_ff;
   logic [2:0]        nxt_byte;
   logic [7:0]        sh_ff;
   logic [7:0]        nxt_sh;
   logic [7:0]        crc_ff;
   logic [7:0]        nxt_crc;
   logic              edge_ff;
   logic              nxt_edge;
   logic              wr_ff;
   logic              nxt_wr;
   logic [6:0]        addr_ff;
   logic [6:0]        nxt_addr;
   logic [31:0]       data_ff;
   logic [31:0]       nxt_data;
   logic [TX_BITS-1:0] tx_ff;
   logic [TX_BITS-1:0] nxt_tx;
   logic              out_ff;
   logic              nxt_out;
   logic              oe_ff;
   logic              nxt_oe;
   logic              rdq_ff;
   logic              nxt_rdq;
   logic [7:0]        count_ff;
   logic [7:0]        nxt_count;
   logic [GAP_W-1:0]  lim63;
   logic [GAP_W-1:0]  lim12;
   logic [CNT_W-1:0]  meas;
   logic [CNT_W-1:0]  half;
   logic [2:0]        last;
   logic [6:0]        dly_bits;
   logic [7:0]        tb [TX_BYTES];
   logic [TX_BITS-1:0] frame;

   swu_stream_if #(.W(WR_W)) wq ();

   swu_buf #(.W(WR_W)) u_buf (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_s      (wq.snk),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  ({wr_addr, wr_data})
   );

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_s1_ff  <= 1'b1;
         rx_s2_ff  <= 1'b1;
         rx_prv_ff <= 1'b1;
      end
      else
      begin
         rx_s1_ff  <= wire_data_true_in;
         rx_s2_ff  <= rx_s1_ff;
         rx_prv_ff <= rx_s2_ff;
      end
   end

   assign fall  = rx_prv_ff && !rx_s2_ff;
   assign rise  = !rx_prv_ff && rx_s2_ff;
   // Timeouts use the bit time of the last good datagram, not the one
   // being measured, so a bad sync cannot stretch its own timeout.
   assign lim63 = GAP_W'(good_ff) * GAP_W'(TIMEOUT_BITS);
   assign lim12 = GAP_W'(good_ff) * GAP_W'(RECOV_BITS);
   assign meas  = (cnt_ff + CNT_W'(1)) >> 2;
   assign half  = bit_ff >> 1;
   assign last  = wr_ff ? WR_LAST : RD_LAST;
   assign dly_bits = (reply_delay_setting == 4'h0) ? 7'(DELAY_UNIT)
                   : {reply_delay_setting, 3'h0};

   always_comb
   begin
      tb[0] = SYNC_BYTE;
      tb[1] = {1'b0, addr_ff};
      for (int i = 0; i < 4; i++)
      begin
         tb[2 + i] = rd_data[(3 - i) * 8 +: 8];
      end
      tb[TX_BYTES - 1] = 8'h00;
      for (int i = 0; i < TX_BYTES - 1; i++)
      begin
         tb[TX_BYTES - 1] = swu_crc(tb[TX_BYTES - 1], tb[i]);
      end
      for (int i = 0; i < TX_BYTES; i++)
      begin
         frame[i * 10 +: 10] = {1'b1, tb[i], 1'b0};
      end
   end

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_gap   = gap_ff;
      nxt_bit   = bit_ff;
      nxt_good  = good_ff;
      nxt_idx   = idx_ff;
      nxt_byte  = byte_ff;
      nxt_sh    = sh_ff;
      nxt_crc   = crc_ff;
      nxt_edge  = edge_ff;
      nxt_wr    = wr_ff;
      nxt_addr  = addr_ff;
      nxt_data  = data_ff;
      nxt_tx    = tx_ff;
      nxt_rdq   = 1'b0;
      nxt_count = count_ff;
      wq.valid  = 1'b0;
      wq.data   = {addr_ff, data_ff};
      case (state_ff)
         S_IDLE:
         begin
            nxt_crc  = 8'h00;
            nxt_byte = 3'h0;
            if (fall)
            begin
               nxt_state = S_MEAS;
               nxt_cnt   = '0;
               nxt_edge  = 1'b0;
            end
         end
         S_MEAS:
         begin
            nxt_cnt = cnt_ff + CNT_W'(1);
            if (rise && !edge_ff && cnt_ff < CNT_W'(GLITCH_CYC - 1))
            begin
               nxt_state = S_RECOV;
               nxt_gap   = '0;
            end
            else if (fall && !edge_ff)
               nxt_edge = 1'b1;
            else if (fall && meas < CNT_W'(MIN_BIT_CYC))
            begin
               nxt_state = S_RECOV;
               nxt_gap   = '0;
            end
            else if (fall)
            begin
               nxt_bit   = meas;
               nxt_state = S_BYTE;
               nxt_cnt   = (meas >> 1) - CNT_W'(1);
               nxt_idx   = SYNC_IDX;
               nxt_sh    = SYNC_PRELOAD;
               nxt_gap   = GAP_W'(cnt_ff);
            end
            else if (&cnt_ff)
            begin
               nxt_state = S_RECOV;
               nxt_gap   = '0;
            end
         end
         S_WAITB:
         begin
            nxt_gap = gap_ff + GAP_W'(1);
            if (gap_ff > lim63)
               nxt_state = S_IDLE;
            else if (fall)
            begin
               nxt_state = S_BYTE;
               nxt_gap   = '0;
               nxt_idx   = 7'h00;
               nxt_cnt   = half - CNT_W'(1);
            end
         end
         S_BYTE:
         begin
            nxt_gap = gap_ff + GAP_W'(1);
            if (gap_ff > lim63)
               nxt_state = S_IDLE;
            else if (cnt_ff != '0)
               nxt_cnt = cnt_ff - CNT_W'(1);
            else
            begin
               nxt_cnt = bit_ff - CNT_W'(1);
               nxt_idx = idx_ff + 7'h01;
               if (idx_ff == 7'h00)
               begin
                  if (rx_s2_ff)
                  begin
                     nxt_state = S_RECOV;
                     nxt_gap   = '0;
                  end
               end
               else if (idx_ff <= 7'h08)
                  nxt_sh = {rx_s2_ff, sh_ff[7:1]};
               else if (!rx_s2_ff)
               begin
                  nxt_state = S_RECOV;
                  nxt_gap   = '0;
               end
               else
               begin
                  nxt_state = S_WAITB;
                  nxt_byte  = byte_ff + 3'h1;
                  nxt_crc   = swu_crc(crc_ff, sh_ff);
                  if (byte_ff == 3'h0 && sh_ff != SYNC_BYTE)
                  begin
                     nxt_state = S_RECOV;
                     nxt_gap   = '0;
                  end
                  else if (byte_ff == 3'h1)
                  begin
                     nxt_wr   = sh_ff[7];
                     nxt_addr = sh_ff[6:0];
                  end
                  else if (byte_ff != last)
                     nxt_data = {data_ff[23:0], sh_ff};
                  else if (sh_ff != crc_ff)
                  begin
                     nxt_state = S_RECOV;
                     nxt_gap   = '0;
                  end
                  else
                  begin
                     nxt_good = bit_ff;
                     if (wr_ff)
                        nxt_state = S_COMMIT;
                     else
                     begin
                        nxt_state = S_DELAY;
                        nxt_rdq   = 1'b1;
                        nxt_idx   = 7'h00;
                     end
                  end
               end
            end
         end
         S_COMMIT:
         begin
            wq.valid = 1'b1;
            if (wq.ready)
            begin
               nxt_count = count_ff + 8'h01;
               nxt_state = S_IDLE;
            end
         end
         S_DELAY:
         begin
            if (cnt_ff != '0)
               nxt_cnt = cnt_ff - CNT_W'(1);
            else if (idx_ff >= dly_bits - 7'h01)
            begin
               nxt_state = S_SEND;
               nxt_tx    = frame;
               nxt_idx   = 7'h00;
               nxt_cnt   = bit_ff - CNT_W'(1);
            end
            else
            begin
               nxt_idx = idx_ff + 7'h01;
               nxt_cnt = bit_ff - CNT_W'(1);
            end
         end
         S_SEND:
         begin
            if (cnt_ff != '0)
               nxt_cnt = cnt_ff - CNT_W'(1);
            else
            begin
               nxt_cnt = bit_ff - CNT_W'(1);
               nxt_tx  = {1'b1, tx_ff[TX_BITS-1:1]};
               nxt_idx = idx_ff + 7'h01;
               if (idx_ff == 7'(TX_BITS - 1))
               begin
                  nxt_state = S_HOLD;
                  nxt_idx   = 7'h00;
               end
            end
         end
         S_HOLD:
         begin
            if (cnt_ff != '0)
               nxt_cnt = cnt_ff - CNT_W'(1);
            else
            begin
               nxt_cnt = bit_ff - CNT_W'(1);
               nxt_idx = idx_ff + 7'h01;
               if (idx_ff == 7'(HOLD_BITS - 1))
                  nxt_state = S_IDLE;
            end
         end
         S_RECOV:
         begin
            if (!rx_s2_ff)
               nxt_gap = '0;
            else if (gap_ff >= lim12)
               nxt_state = S_IDLE;
            else
               nxt_gap = gap_ff + GAP_W'(1);
         end
         default:
            nxt_state = S_IDLE;
      endcase
      nxt_oe  = (nxt_state == S_SEND) || (nxt_state == S_HOLD);
      nxt_out = (nxt_state == S_SEND) ? nxt_tx[0] : 1'b1;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= S_IDLE;
         cnt_ff   <= '0;
         gap_ff   <= '0;
         bit_ff   <= CNT_W'(BIT_RESET);
         good_ff  <= CNT_W'(BIT_RESET);
         idx_ff   <= 7'h00;
         byte_ff  <= 3'h0;
         sh_ff    <= 8'h00;
         crc_ff   <= 8'h00;
         edge_ff  <= 1'b0;
         wr_ff    <= 1'b0;
         addr_ff  <= 7'h00;
         data_ff  <= 32'h0;
         tx_ff    <= '1;
         out_ff   <= 1'b1;
         oe_ff    <= 1'b0;
         rdq_ff   <= 1'b0;
         count_ff <= 8'h00;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         gap_ff   <= nxt_gap;
         bit_ff   <= nxt_bit;
         good_ff  <= nxt_good;
         idx_ff   <= nxt_idx;
         byte_ff  <= nxt_byte;
         sh_ff    <= nxt_sh;
         crc_ff   <= nxt_crc;
         edge_ff  <= nxt_edge;
         wr_ff    <= nxt_wr;
         addr_ff  <= nxt_addr;
         data_ff  <= nxt_data;
         tx_ff    <= nxt_tx;
         out_ff   <= nxt_out;
         oe_ff    <= nxt_oe;
         rdq_ff   <= nxt_rdq;
         count_ff <= nxt_count;
      end
   end

   assign wire_data_true_out = out_ff;
   assign wire_data_true_oe  = oe_ff;
   assign rd_req             = rdq_ff;
   assign rd_addr            = addr_ff;
   assign dgram_count        = count_ff;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   drive_reply_a: assert property (oe_ff == (state_ff == S_SEND
      || state_ff == S_HOLD))
      else $error("line driven outside reply");
   start_low_a: assert property ($rose(oe_ff) |-> !out_ff)
      else $error("reply does not open with start bit");
   hold_high_a: assert property (state_ff == S_HOLD |-> out_ff)
      else $error("line not high while holding");
   write_count_a: assert property (wq.valid && wq.ready
      |=> count_ff == $past(count_ff) + 8'h01)
      else $error("write not counted");
   read_count_a: assert property (state_ff == S_DELAY
      |-> $stable(count_ff))
      else $error("read changed counter");
   crc_gate_a: assert property (state_ff == S_BYTE && nxt_state == S_COMMIT
      |-> sh_ff == crc_ff && wr_ff)
      else $error("write accepted with bad check byte");
   glitch_trap_a: assert property (state_ff == S_MEAS && rise && !edge_ff
      && cnt_ff < CNT_W'(15) |=> state_ff == S_RECOV)
      else $error("glitch not trapped");
   gap_reset_a: assert property (state_ff == S_WAITB && gap_ff > lim63
      |=> state_ff == S_IDLE)
      else $error("gap timeout missed");
   bit_meas_a: assert property (state_ff == S_MEAS && nxt_state == S_BYTE
      |=> bit_ff == ($past(cnt_ff) + CNT_W'(1)) >> 2)
      else $error("bit time mismeasured");
   sync_check_a: assert property (state_ff == S_BYTE && idx_ff == 7'h09
      && cnt_ff == '0 && byte_ff == 3'h0 && sh_ff != SYNC_BYTE
      |=> state_ff == S_RECOV)
      else $error("bad sync accepted");

   write_done_c: cover property (wq.valid && wq.ready);
   reply_sent_c: cover property ($fell(oe_ff));
   glitch_seen_c: cover property (state_ff == S_MEAS
      && nxt_state == S_RECOV);
   timeout_seen_c: cover property (state_ff == S_WAITB
      && nxt_state == S_IDLE);
endmodule

// [swu_master_model.sv]
`timescale 1ns/1ps
// Master on the shared line; between its own frames it lets the line go
// to the pull-up level, so a reply from the device is seen unaltered.
module swu_master_model
(
   input  wire logic core_clk,
   input  wire logic line,
   output logic      drv
);
   int         bit_cyc;
   logic       busy;
   logic [7:0] rx_q[$];
   time        t_rx;

   initial
   begin
      drv = 1'b1;
      busy = 1'b0;
      bit_cyc = 32;
   end

   task automatic send(input logic [7:0] q[$], input int bc);
      logic [9:0] f;
      busy = 1'b1;
      bit_cyc = bc;
      foreach (q[i])
      begin
         f = {1'b1, q[i], 1'b0};
         for (int k = 0; k < 10; k++)
         begin
            drv <= f[k];
            repeat (bc) @(posedge core_clk);
         end
      end
      busy = 1'b0;
   endtask

   task automatic glitch(input int n);
      busy = 1'b1;
      drv <= 1'b0;
      repeat (n) @(posedge core_clk);
      drv <= 1'b1;
      repeat (2) @(posedge core_clk);
      busy = 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n * bit_cyc) @(posedge core_clk);
   endtask

   always
   begin
      logic [7:0] b;
      @(negedge line);
      if (!busy)
      begin
         if (rx_q.size() == 0)
            t_rx = $time;
         repeat (bit_cyc / 2) @(posedge core_clk);
         for (int k = 0; k < 8; k++)
         begin
            repeat (bit_cyc) @(posedge core_clk);
            b[k] = line;
         end
         repeat (bit_cyc) @(posedge core_clk);
         rx_q.push_back(b);
      end
   end
endmodule

// [swu_slave_tb_top.sv]
`timescale 1ns/1ps
module swu_slave_tb_top;
   logic        core_clk;
   logic        rst;
   logic        line;
   logic        m_drv;
   logic        d_out;
   logic        d_oe;
   logic [3:0]  dly;
   logic        wr_valid;
   logic        wr_ready;
   logic [6:0]  wr_addr;
   logic [31:0] wr_data;
   logic        rd_req;
   logic [6:0]  rd_addr;
   logic [31:0] rd_data;
   logic [7:0]  dgram_count;
   logic [31:0] lfsr_st = 32'h3;
   logic [31:0] rdv;
   logic [6:0]  rq_addr;
   logic        stall;
   logic        clash = 1'b0;
   logic [38:0] wq[$];
   logic [7:0]  eq[$];
   int          fails;
   int          checked;
   int          cnt;
   int          cyc;
   int          dt;
   time         t_req;

   assign line = (d_oe === 1'b1) ? d_out : m_drv;

   swu_slave #(.BIT_RESET(40)) dut_u (
      .core_clk           (core_clk),
      .rst                (rst),
      .wire_data_true_in  (line),
      .wire_data_true_out (d_out),
      .wire_data_true_oe  (d_oe),
      .reply_delay_setting(dly),
      .wr_valid           (wr_valid),
      .wr_ready           (wr_ready),
      .wr_addr            (wr_addr),
      .wr_data            (wr_data),
      .rd_req             (rd_req),
      .rd_addr            (rd_addr),
      .rd_data            (rd_data),
      .dgram_count        (dgram_count)
   );

   swu_master_model m_u (
      .core_clk(core_clk),
      .line    (line),
      .drv     (m_drv)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] crc8(input logic [7:0] q[$]);
      logic [7:0] c;
      c = 8'h00;
      foreach (q[i])
         for (int k = 0; k < 8; k++)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ q[i][k]) ? 8'h07 : 8'h00);
      return c;
   endfunction

   task automatic chk_w(input string n, input logic [38:0] e,
                        input logic [38:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_b(input string n, input logic [7:0] e,
                        input logic [7:0] g);
      chk_w(n, {31'h0, e}, {31'h0, g});
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Kinds: 0 write, 1 read, 2 bad check byte, 3 bad sync, 4 cut short.
   task automatic send_dg(input int kind, input logic [6:0] a,
                          input logic [31:0] d, input int bc);
      logic [7:0] q[$];
      q = '{8'h05, {(kind != 1), a}};
      if (kind == 3)
         q[0] = 8'h15;
      if (kind != 1)
         for (int i = 3; i >= 0; i--)
            q.push_back(d[i*8 +: 8]);
      q.push_back(crc8(q) ^ ((kind == 2) ? 8'h01 : 8'h00));
      while (kind == 4 && q.size() > 2)
         void'(q.pop_back());
      if (kind == 0)
      begin
         wq.push_back({a, d});
         cnt++;
      end
      m_u.send(q, bc);
   endtask

   task automatic drain_and_count();
      for (int j = 0; j < 4000 && wq.size() > 0; j++)
         @(posedge core_clk);
      chk_b("dgram_count", cnt[7:0], dgram_count);
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cyc++;
      wr_ready <= !stall && lfsr_st[0];
      lfsr_st <= lfsr(lfsr_st);
      if (rst === 1'b0 && wr_valid === 1'b1 && wr_ready === 1'b1)
      begin
         if (wq.size() == 0)
            wq.push_back('x);
         chk_w("wr_word", wq.pop_front(), {wr_addr, wr_data});
      end
      if (rst === 1'b0 && rd_req === 1'b1)
      begin
         t_req = $time;
         chk_b("rd_addr", {1'b0, rq_addr}, {1'b0, rd_addr});
      end
      if (d_oe === 1'b1 && m_drv === 1'b0)
         clash <= 1'b1;
      if (cyc > 90000)
      begin
         fails++;
         give_verdict();
      end
   end

   initial
   begin
      rst = 1'b1;
      stall = 1'b1;
      // Reply inputs start at values taken from the LFSR seed; each read test sets its own before use.
      dly = lfsr_st[3:0];
      rd_data = ~lfsr_st;
      rq_addr = 7'h00;
      fails = 0;
      checked = 0;
      cnt = 0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      // The receiver stalls through three writes so both entries fill.
      for (int i = 0; i < 5; i++)
      begin
         send_dg(0, lfsr_st[14:8], lfsr_st, (i < 3) ? 32 : 20);
         if (i == 2)
            stall <= 1'b0;
         m_u.idle(4);
      end
      drain_and_count();
      $display("test writes done");
      for (int k = 2; k <= 5; k++)
      begin
         if (k == 5)
            m_u.glitch(5);
         else
            send_dg(k, 7'h11, lfsr_st, 20);
         m_u.idle(70);
         send_dg(0, 7'h22, lfsr_st, 20);
         m_u.idle(4);
      end
      drain_and_count();
      $display("test errors done");
      for (int k = 0; k < 2; k++)
      begin
         rdv = lfsr_st;
         rq_addr = lfsr_st[22:16];
         rd_data <= rdv;
         dly <= 4'(2 * k);
         m_u.rx_q.delete();
         send_dg(1, rq_addr, 32'h0, 24 + 8 * k);
         for (int j = 0; j < 20000 && m_u.rx_q.size() < 7; j++)
            @(posedge core_clk);
         eq = '{8'h05, {1'b0, rq_addr}};
         for (int i = 3; i >= 0; i--)
            eq.push_back(rdv[i*8 +: 8]);
         eq.push_back(crc8(eq));
         for (int i = 0; i < 7; i++)
            chk_b("reply_byte", eq[i], m_u.rx_q[i]);
         dt = int'((m_u.t_rx - t_req) / 8);
         chk_b("reply_wait", 8'h1, 8'(dt >= (k + 1) * 8 * (24 + 8 * k) - 1
               && dt <= (k + 1) * 8 * (24 + 8 * k) + 4));
         m_u.idle(2);
         chk_b("oe_hold", 8'h1, {7'h0, d_oe});
         m_u.idle(4);
         chk_b("oe_release", 8'h0, {7'h0, d_oe});
         chk_b("dgram_count", cnt[7:0], dgram_count);
      end
      $display("test reads done");
      chk_b("line_clash", 8'h0, {7'h0, clash});
      give_verdict();
   end
endmodule
